// ---- bpa_addr_map.sv ----
`timescale 1ns/1ps
`default_nettype none

module bpa_addr_map
    import bpa_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 resetn,
    input  wire logic                 load,
    input  wire logic [WORD_W-1:0]    addr_in,
    output var  logic [BADDR_W-1:0]   addr_q
);
    // ------------------------------------------------------------
    // 16-bit program address to 18-bit bus byte address
    // ------------------------------------------------------------
    wire logic       in_io_page;
    wire logic [1:0] ext_bits;

    assign in_io_page = (addr_in[WORD_W-1:IO_TOP_LSB] == IO_TOP_BITS);
    assign ext_bits   = in_io_page ? IO_EXT_BITS : LOW_EXT;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            addr_q <= '0;
        end else if (load) begin
            addr_q <= {ext_bits, addr_in};
        end
    end

endmodule

`default_nettype wire

// ---- bpa_arbiter.sv ----
`timescale 1ns/1ps
`default_nettype none

module bpa_arbiter
    import bpa_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 resetn,
    // bus side pins
    input  wire logic                 npr_req,
    input  wire logic [LEVELS-1:0]    br_req,
    input  wire logic                 sack_in,
    input  wire logic                 bbsy_in,
    input  wire logic                 ssyn_in,
    input  wire logic                 interrupt_transaction_in,
    input  wire logic [WORD_W-1:0]    data_in,
    input  wire logic                 console_step_request,
    output var  bpa_grant_s           grant_q,
    output var  logic [BADDR_W-1:0]   bus_addr,
    output var  logic                 addr_oe_q,
    output var  bpa_kind_e            bus_ctl_q,
    output var  logic                 msyn_q,
    output var  logic                 bbsy_out_q,
    output var  logic [WORD_W-1:0]    data_out_q,
    output var  logic                 data_oe_q,
    output var  logic                 ssyn_out_q,
    // processor core side, same clock
    input  wire logic                 cpu_xfer_valid,
    input  wire bpa_xfer_s            cpu_xfer,
    input  wire logic                 instr_done,
    input  wire logic                 wait_trap_point,
    input  wire logic                 prio_wr,
    input  wire logic [PRIO_W-1:0]    prio_wdata,
    input  wire logic                 console_deposit,
    input  wire logic                 console_examine,
    input  wire logic [WORD_W-1:0]    console_addr,
    input  wire logic [WORD_W-1:0]    console_data,
    output var  logic                 xfer_done_q,
    output var  logic                 console_done_q,
    output var  logic [WORD_W-1:0]    rdata_q,
    output var  logic                 vec_valid_q,
    output var  logic [WORD_W-1:0]    vec_q,
    output var  logic [PRIO_W-1:0]    cpu_prio_q,
    output var  logic                 proc_master_q
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // requests are asynchronous to our clock, so every pin is resampled
    logic               npr_m_q,  npr_s_q;
    logic [LEVELS-1:0]  br_m_q,   br_s_q;
    logic               sack_m_q, sack_s_q;
    logic               bbsy_m_q, bbsy_s_q;
    logic               ssyn_m_q, ssyn_s_q;
    logic               interrupt_transaction_m_q, interrupt_transaction_s_q;
    logic               step_m_q, step_s_q;
    logic [WORD_W-1:0]  data_m_q, data_s_q;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            {npr_m_q, br_m_q, sack_m_q, bbsy_m_q} <= '0;
            {ssyn_m_q, interrupt_transaction_m_q, step_m_q, data_m_q} <= '0;
            {npr_s_q, br_s_q, sack_s_q, bbsy_s_q} <= '0;
            {ssyn_s_q, interrupt_transaction_s_q, step_s_q, data_s_q} <= '0;
        end else begin
            {npr_m_q, br_m_q, sack_m_q, bbsy_m_q} <= {npr_req, br_req, sack_in, bbsy_in};
            {ssyn_m_q, interrupt_transaction_m_q, step_m_q, data_m_q}
                <= {ssyn_in, interrupt_transaction_in, console_step_request, data_in};
            {npr_s_q, br_s_q, sack_s_q, bbsy_s_q} <= {npr_m_q, br_m_q, sack_m_q, bbsy_m_q};
            {ssyn_s_q, interrupt_transaction_s_q, step_s_q, data_s_q}
                <= {ssyn_m_q, interrupt_transaction_m_q, step_m_q, data_m_q};
        end
    end

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // one-hot of the highest requested level strictly above the floor
    function automatic logic [LEVELS-1:0] pick_level(
        input logic [LEVELS-1:0]  req,
        input logic [PRIO_W-1:0]  floor
    );
        logic [LEVELS-1:0] hot;
        logic [PRIO_W-1:0] lvl;
        hot = '0;
        for (int i = 0; i < LEVELS; i++) begin
            lvl = LEVEL_BASE + PRIO_W'(i);
            if (req[i] && (lvl > floor)) begin
                hot = '0;
                hot[i] = 1'b1;
            end
        end
        return hot;
    endfunction

    function automatic logic is_write(input bpa_kind_e k);
        return (k == word_write_transfer) || (k == byte_write_transfer);
    endfunction

    // ------------------------------------------------------------
    // processor priority
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cpu_prio_q <= PRIO_RESET;
        end else if (prio_wr) begin
            cpu_prio_q <= prio_wdata;
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_GRANT,
        ST_HELD,
        ST_ADDR,
        ST_DRIVE,
        ST_WAIT,
        ST_END
    } bpa_state_e;

    bpa_state_e  state_q, state_d;
    bpa_xfer_s   cur_q;
    logic        cur_console_q;
    logic        pend_q;
    logic        vec_taken_q;
    logic        interrupt_transaction_prev_q;

    // ------------------------------------------------------------
    // arbitration decode
    // ------------------------------------------------------------
    wire logic               npr_point;
    wire logic               instr_point;
    wire logic               take_npr;
    wire logic               take_step;
    wire logic [LEVELS-1:0]  br_hot;
    wire logic               take_br;
    wire logic               take_any;
    bpa_grant_s              grant_next;
    wire logic               console_go;
    wire bpa_xfer_s          console_xfer;
    wire logic               released;
    wire logic               interrupt_transaction_rise;
    // before a data cycle (pending work), after one, or inside wait/trap
    assign npr_point   = pend_q | cpu_xfer_valid | wait_trap_point
                       | (state_q == ST_END);
    assign instr_point = instr_done;
    assign take_npr    = npr_s_q && npr_point;
    assign br_hot      = pick_level(br_s_q, cpu_prio_q);
    assign take_step   = !take_npr && step_s_q && instr_point;
    assign take_br     = !take_npr && !take_step && instr_point
                       && (br_hot != '0);
    assign take_any    = take_npr | take_step | take_br;
    always_comb begin
        grant_next      = GRANT_NONE;
        grant_next.nonprocessor_request  = take_npr;
        grant_next.step = take_step;
        grant_next.br   = take_br ? br_hot : '0;
    end
    // console accesses go through the same transfer engine
    assign console_go   = console_deposit | console_examine;
    assign console_xfer = '{kind  : (console_deposit ? word_write_transfer
                                                     : read_transfer),
                            addr  : console_addr,
                            wdata : console_data};
    // tenure ends only when the master has dropped both select and busy
    assign released  = !sack_s_q && !bbsy_s_q;
    assign interrupt_transaction_rise = interrupt_transaction_s_q && !interrupt_transaction_prev_q;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (take_any) state_d = ST_GRANT;
                else if (pend_q) state_d = ST_ADDR;
            end
            ST_GRANT: if (sack_s_q) state_d = ST_HELD;
            ST_HELD:  if (released) state_d = ST_IDLE;
            ST_ADDR:  state_d = ST_DRIVE;
            ST_DRIVE: state_d = ST_WAIT;
            ST_WAIT:  if (ssyn_s_q) state_d = ST_END;
            ST_END:   if (!ssyn_s_q) state_d = take_npr ? ST_GRANT : ST_IDLE;
            default:  state_d = ST_IDLE;
        endcase
    end

    wire logic grant_fire;
    wire logic xfer_finish;
    wire logic accept_req;
    assign grant_fire  = (state_q == ST_IDLE && take_any)
                       || (state_q == ST_END && !ssyn_s_q && take_npr);
    assign xfer_finish = (state_q == ST_END) && !ssyn_s_q;
    // a new request is accepted only while the engine is free, otherwise it is dropped; one outstanding at a time
    assign accept_req  = !pend_q && (cpu_xfer_valid || console_go);

    // ------------------------------------------------------------
    // pending transfer and grant registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_q       <= ST_IDLE;
            pend_q        <= 1'b0;
            cur_q         <= '0;
            cur_console_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (accept_req) begin
                pend_q        <= 1'b1;
                cur_q         <= cpu_xfer_valid ? cpu_xfer : console_xfer;
                cur_console_q <= !cpu_xfer_valid;
            end else if (xfer_finish) begin
                pend_q        <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            grant_q <= GRANT_NONE;
        end else if (grant_fire) begin
            grant_q <= grant_next;
        end else if (state_q == ST_GRANT && sack_s_q) begin
            grant_q <= GRANT_NONE;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            proc_master_q <= 1'b1;
        end else begin
            proc_master_q <= (state_d == ST_IDLE) || (state_d >= ST_ADDR);
        end
    end

    // ------------------------------------------------------------
    // processor data cycle
    // ------------------------------------------------------------
    bpa_addr_map u_addr_map (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .load    (state_q == ST_ADDR),
        .addr_in (cur_q.addr),
        .addr_q  (bus_addr)
    );
    wire logic driving;
    assign driving = (state_d == ST_DRIVE) || (state_d == ST_WAIT)
                   || (state_d == ST_END && state_q != ST_END);
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            addr_oe_q  <= 1'b0;
            bbsy_out_q <= 1'b0;
            bus_ctl_q  <= read_transfer;
            data_out_q <= '0;
            data_oe_q  <= 1'b0;
            msyn_q     <= 1'b0;
        end else begin
            addr_oe_q  <= driving;
            bbsy_out_q <= driving;
            bus_ctl_q  <= cur_q.kind;
            data_out_q <= cur_q.wdata;
            data_oe_q  <= driving && is_write(cur_q.kind);
            // one clock of address setup before the strobe
            msyn_q     <= (state_d == ST_WAIT);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q        <= '0;
            xfer_done_q    <= 1'b0;
            console_done_q <= 1'b0;
        end else begin
            if (state_q == ST_WAIT && ssyn_s_q && !is_write(cur_q.kind)) begin
                rdata_q <= data_s_q;
            end
            xfer_done_q    <= xfer_finish && !cur_console_q;
            console_done_q <= xfer_finish && cur_console_q;
        end
    end

    // ------------------------------------------------------------
    // vector capture during a granted tenure
    // ------------------------------------------------------------
    // a master that never raises interrupt_transaction simply did a direct transfer instead
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            interrupt_transaction_prev_q <= 1'b0;
            vec_taken_q <= 1'b0;
            vec_valid_q <= 1'b0;
            vec_q       <= '0;
            ssyn_out_q  <= 1'b0;
        end else begin
            interrupt_transaction_prev_q <= interrupt_transaction_s_q;
            vec_valid_q <= 1'b0;
            if (state_q == ST_HELD && interrupt_transaction_rise && !vec_taken_q) begin
                vec_q       <= data_s_q;
                vec_valid_q <= 1'b1;
                vec_taken_q <= 1'b1;
                ssyn_out_q  <= 1'b1;
            end else if (!interrupt_transaction_s_q) begin
                ssyn_out_q  <= 1'b0;
            end
            if (state_q != ST_HELD) vec_taken_q <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ---- bpa_checker.sv ----
`timescale 1ns/1ps
`default_nettype none

module bpa_checker
    import bpa_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               resetn,
    input  wire bpa_grant_s         grant_q,
    input  wire logic               sack_in,
    input  wire logic               msyn_q,
    input  wire logic               ssyn_in,
    input  wire logic               addr_oe_q,
    input  wire logic [BADDR_W-1:0] bus_addr,
    input  wire bpa_kind_e          bus_ctl_q,
    input  wire logic               data_oe_q,
    input  wire logic               xfer_done_q,
    input  wire logic               console_done_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    wire granted = (grant_q != GRANT_NONE);
    wire is_wr   = (bus_ctl_q == word_write_transfer) || (bus_ctl_q == byte_write_transfer);

    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    sequence s_addr_then_msyn;
        !msyn_q ##1 msyn_q;
    endsequence
    sequence s_grant_quiet;
        !granted [*2];
    endsequence

    property p_onehot;
        $onehot0(grant_q);
    endproperty
    a_onehot: assert property (p_onehot) else $error("more than one grant");

    // sack needs two sync edges, so a fresh grant must stand
    property p_grant_stands;
        $rose(granted) |=> $stable(grant_q) [*2];
    endproperty
    a_grant_stands: assert property (p_grant_stands) else $error("grant dropped early");

    property p_grant_quiet;
        $fell(granted) |-> s_grant_quiet;
    endproperty
    a_grant_quiet: assert property (p_grant_quiet) else $error("regrant before release");

    property p_grant_drop;
        $rose(sack_in) |-> ##[2:4] !granted;
    endproperty
    a_grant_drop: assert property (p_grant_drop) else $error("grant held after ack");

    property p_msyn_setup;
        $rose(addr_oe_q) |-> s_addr_then_msyn;
    endproperty
    a_msyn_setup: assert property (p_msyn_setup) else $error("msyn not one cycle after addr");

    property p_addr_hold;
        msyn_q && $past(msyn_q) |-> addr_oe_q && $stable(bus_addr) && $stable(bus_ctl_q);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved during cycle");

    property p_msyn_wait;
        msyn_q && !ssyn_in |=> msyn_q;
    endproperty
    a_msyn_wait: assert property (p_msyn_wait) else $error("msyn dropped without ssyn");

    property p_msyn_drop;
        $rose(ssyn_in) |-> ##[1:4] !msyn_q;
    endproperty
    a_msyn_drop: assert property (p_msyn_drop) else $error("msyn held after ssyn");

    property p_io_map;
        addr_oe_q |-> bus_addr[17:16] == ((&bus_addr[15:13]) ? 2'h3 : 2'h0);
    endproperty
    a_io_map: assert property (p_io_map) else $error("upper address bits wrong");

    property p_data_dir;
        msyn_q |-> data_oe_q == is_wr;
    endproperty
    a_data_dir: assert property (p_data_dir) else $error("data direction wrong");

    property p_done;
        $fell(ssyn_in) |-> ##[1:4] (xfer_done_q || console_done_q);
    endproperty
    a_done: assert property (p_done) else $error("no completion after ssyn");
endmodule

`default_nettype wire

// ---- bpa_periph_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module bpa_periph_model
    import bpa_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               want_npr,
    input  wire logic [LEVELS-1:0]  want_br,
    input  wire logic [WORD_W-1:0]  vec,
    input  wire bpa_grant_s         grant_q,
    input  wire logic               msyn_q,
    input  wire logic               ssyn_out_q,
    input  wire bpa_kind_e          bus_ctl_q,
    input  wire logic [BADDR_W-1:0] bus_addr,
    input  wire logic [WORD_W-1:0]  data_out_q,
    output logic                    npr_req,
    output logic [LEVELS-1:0]       br_req,
    output logic                    sack_in,
    output logic                    bbsy_in,
    output logic                    ssyn_in,
    output logic                    interrupt_transaction_in,
    output logic [WORD_W-1:0]       data_in
);
    logic [WORD_W-1:0] store = '0;
    int                n;

    // requests are raised whenever the bench asks, unaligned
    assign npr_req = want_npr;
    assign br_req  = want_br;

    initial begin
        {sack_in, bbsy_in, ssyn_in, interrupt_transaction_in} = 4'h0;
        data_in = '0;
    end

    // released data lines show the inverse, never the old value
    always begin
        @(posedge ref_clk);
        if (grant_q !== GRANT_NONE) begin
            sack_in <= 1'b1;
            bbsy_in <= 1'b1;
            if (|grant_q.br) begin
                // interrupt_transaction only after the grant was answered and dropped
                repeat (4) @(posedge ref_clk);
                data_in <= vec;
                interrupt_transaction_in <= 1'b1;
                n = 0;
                while (ssyn_out_q !== 1'b1 && n < 40) begin
                    @(posedge ref_clk);
                    n++;
                end
                interrupt_transaction_in <= 1'b0;
            end else begin
                repeat (4) @(posedge ref_clk);
            end
            sack_in <= 1'b0;
            bbsy_in <= 1'b0;
            data_in <= ~data_in;
            repeat (3) @(posedge ref_clk);
        end else if (msyn_q === 1'b1) begin
            repeat (2) @(posedge ref_clk);
            if (bus_ctl_q == word_write_transfer) begin
                store <= data_out_q;
            end else if (bus_ctl_q == byte_write_transfer) begin
                if (bus_addr[0]) store[15:8] <= data_out_q[15:8];
                else store[7:0] <= data_out_q[7:0];
            end else begin
                data_in <= store;
            end
            ssyn_in <= 1'b1;
            n = 0;
            while (msyn_q === 1'b1 && n < 40) begin
                @(posedge ref_clk);
                n++;
            end
            ssyn_in <= 1'b0;
            data_in <= ~data_in;
        end
    end
endmodule

`default_nettype wire

// ---- bpa_pkg.sv ----
package bpa_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned WORD_W   = 16;
    localparam int unsigned BADDR_W  = 18;
    localparam int unsigned LEVELS   = 4;
    localparam int unsigned PRIO_W   = 3;

    // ------------------------------------------------------------
    // address map: top 4K words of the 16-bit space is the i/o page
    // ------------------------------------------------------------
    localparam int unsigned  IO_TOP_LSB  = 13;
    localparam logic [2:0]   IO_TOP_BITS = 3'h7;
    localparam logic [1:0]   IO_EXT_BITS = 2'h3;
    localparam logic [1:0]   LOW_EXT     = 2'h0;

    // hardware request level n sits at processor priority LEVEL_BASE + n
    localparam logic [PRIO_W-1:0] LEVEL_BASE = 3'h4;
    localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h0;

    // ------------------------------------------------------------
    // bus control code driven with the address
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        read_transfer       = 2'h0,
        read_pause_transfer = 2'h1,
        word_write_transfer = 2'h2,
        byte_write_transfer = 2'h3
    } bpa_kind_e;

    typedef struct packed {
        bpa_kind_e          kind;
        logic [WORD_W-1:0]  addr;
        logic [WORD_W-1:0]  wdata;
    } bpa_xfer_s;

    typedef struct packed {
        logic               nonprocessor_request;
        logic [LEVELS-1:0]  br;
        logic               step;
    } bpa_grant_s;

    localparam bpa_grant_s GRANT_NONE = '0;

endpackage

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import bpa_pkg::*;
    logic ref_clk = 1'b0, resetn = 1'b0, console_step_request = 1'b0;
    logic cpu_xfer_valid = 1'b0, instr_done = 1'b0, wait_trap_point = 1'b0;
    logic console_deposit = 1'b0, console_examine = 1'b0, prio_wr = 1'b0, want_npr = 1'b0;
    logic [PRIO_W-1:0] prio_wdata = '0;
    logic [LEVELS-1:0] want_br = '0;
    logic [WORD_W-1:0] console_addr = '0, console_data = '0, vec = 16'h00C0;
    bpa_xfer_s cpu_xfer = '0;
    logic npr_req, sack_in, bbsy_in, ssyn_in, interrupt_transaction_in, addr_oe_q, msyn_q, bbsy_out_q;
    logic data_oe_q, ssyn_out_q, xfer_done_q, console_done_q, vec_valid_q, proc_master_q;
    logic [LEVELS-1:0] br_req;
    logic [WORD_W-1:0] data_in, data_out_q, rdata_q, vec_q;
    logic [BADDR_W-1:0] bus_addr;
    logic [PRIO_W-1:0] cpu_prio_q;
    bpa_grant_s grant_q;
    bpa_kind_e bus_ctl_q;
    int err_count = 0, n_compared = 0;
    wire [5:0] flags = {~|grant_q, |grant_q, vec_valid_q, console_done_q, xfer_done_q, msyn_q};

    always #20 ref_clk = ~ref_clk;

    bpa_arbiter u_dut (.ref_clk, .resetn, .npr_req, .br_req, .sack_in, .bbsy_in, .ssyn_in,
        .interrupt_transaction_in, .data_in, .console_step_request, .grant_q, .bus_addr, .addr_oe_q, .bus_ctl_q,
        .msyn_q, .bbsy_out_q, .data_out_q, .data_oe_q, .ssyn_out_q, .cpu_xfer_valid, .cpu_xfer,
        .instr_done, .wait_trap_point, .prio_wr, .prio_wdata, .console_deposit, .console_examine,
        .console_addr, .console_data, .xfer_done_q, .console_done_q, .rdata_q, .vec_valid_q,
        .vec_q, .cpu_prio_q, .proc_master_q);

    bpa_periph_model u_far (.ref_clk, .want_npr, .want_br, .vec, .grant_q, .msyn_q, .ssyn_out_q,
        .bus_ctl_q, .bus_addr, .data_out_q, .npr_req, .br_req, .sack_in, .bbsy_in, .ssyn_in,
        .interrupt_transaction_in, .data_in);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [BADDR_W-1:0] got, input logic [BADDR_W-1:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wait_flag(input int i);
        int n;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (flags[i] !== 1'b1 && n < 300);
        if (flags[i] !== 1'b1) begin
            err_count++;
            $display("[FAIL] %0t wait %0d timed out", $time, i);
            results();
        end
    endtask

    // mask order: cpu transfer, instr end, wait/trap, deposit, examine
    task automatic pulse_in(input logic [4:0] m, input bpa_xfer_s x);
        @(posedge ref_clk);
        {cpu_xfer_valid, instr_done, wait_trap_point, console_deposit, console_examine} <= m;
        cpu_xfer <= x;
        console_addr <= x.addr;
        console_data <= x.wdata;
        @(posedge ref_clk);
        {cpu_xfer_valid, instr_done, wait_trap_point, console_deposit, console_examine} <= 5'h0;
    endtask

    task automatic one_xfer(input logic con, input bpa_kind_e k, input logic [15:0] a,
                            input logic [15:0] wd, input logic [17:0] ea, input logic [15:0] er);
        logic wr;
        wr = (k == word_write_transfer) || (k == byte_write_transfer);
        pulse_in(con ? (wr ? 5'h02 : 5'h01) : 5'h10, '{kind: k, addr: a, wdata: wd});
        wait_flag(0);
        chk(bus_addr, ea, "bus address");
        chk(18'(bbsy_out_q), 18'h1, "processor busy");
        chk(18'(bus_ctl_q), 18'(k), "transfer kind");
        if (wr) chk(18'(data_out_q), 18'(wd), "write data");
        wait_flag(con ? 2 : 1);
        if (!wr) chk(18'(rdata_q), 18'(er), "read data");
    endtask

    task automatic settle();
        wait_flag(5);
        repeat (12) @(negedge ref_clk);
        chk(18'(proc_master_q), 18'h1, "processor owns idle bus");
    endtask

    task automatic serve(input logic [5:0] g, input logic br);
        pulse_in(br ? 5'h08 : 5'h0C, '0);
        wait_flag(4);
        chk(18'(grant_q), 18'(g), "grant");
        want_npr <= 1'b0;
        if (br) begin
            want_br <= '0;
            wait_flag(3);
            chk(18'(vec_q), 18'(vec), "vector");
        end
        settle();
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_transfers();
        one_xfer(0, word_write_transfer, 16'h1000, 16'h1234, 18'h01000, '0);
        one_xfer(0, byte_write_transfer, 16'h1001, 16'hAB00, 18'h01001, '0);
        one_xfer(0, read_pause_transfer, 16'h1000, '0, 18'h01000, 16'hAB34);
        one_xfer(0, read_transfer, 16'hDFFE, '0, 18'h0DFFE, 16'hAB34);
        one_xfer(0, read_transfer, 16'hE000, '0, 18'h3E000, 16'hAB34);
        one_xfer(0, read_transfer, 16'hF694, '0, 18'h3F694, 16'hAB34);
        $display("test transfers done");
    endtask

    task automatic t_console();
        one_xfer(1, word_write_transfer, 16'h0200, 16'h5A5A, 18'h00200, '0);
        one_xfer(1, read_transfer, 16'h0200, '0, 18'h00200, 16'h5A5A);
        $display("test console done");
    endtask

    task automatic t_levels();
        @(posedge ref_clk);
        prio_wr <= 1'b1;
        prio_wdata <= 3'h5;
        @(posedge ref_clk);
        prio_wr <= 1'b0;
        repeat (2) @(negedge ref_clk);
        chk(18'(cpu_prio_q), 18'h5, "processor level");
        want_br <= 4'h1;
        repeat (4) @(posedge ref_clk);
        pulse_in(5'h08, '0);
        repeat (8) @(negedge ref_clk);
        chk(18'(grant_q), 18'h0, "level not above processor");
        want_br <= 4'h5;
        repeat (4) @(posedge ref_clk);
        vec <= 16'h0104;
        serve(6'h08, 1'b1);
        $display("test levels done");
    endtask

    task automatic t_npr_first();
        want_npr <= 1'b1;
        want_br <= 4'h8;
        repeat (4) @(posedge ref_clk);
        serve(6'h20, 1'b0);
        vec <= 16'h0230;
        serve(6'h10, 1'b1);
        $display("test npr first done");
    endtask

    task automatic t_step();
        @(posedge ref_clk);
        want_br <= 4'h8;
        console_step_request <= 1'b1;
        repeat (4) @(posedge ref_clk);
        pulse_in(5'h08, '0);
        wait_flag(4);
        chk(18'(grant_q), 18'h01, "step beats interrupts");
        @(posedge ref_clk);
        console_step_request <= 1'b0;
        want_br <= '0;
        settle();
        $display("test step done");
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        @(negedge ref_clk);
        chk(18'(grant_q), 18'h0, "reset grant");
        chk(18'(proc_master_q), 18'h1, "reset master");
        chk(18'(cpu_prio_q), 18'h0, "reset level");
        repeat (3) @(negedge ref_clk);
        t_transfers();
        t_console();
        t_levels();
        t_npr_first();
        t_step();
        results();
    end
endmodule

bind bpa_arbiter bpa_checker u_chk (.ref_clk(ref_clk), .resetn(resetn), .grant_q(grant_q),
    .sack_in(sack_in), .msyn_q(msyn_q), .ssyn_in(ssyn_in), .addr_oe_q(addr_oe_q),
    .bus_addr(bus_addr), .bus_ctl_q(bus_ctl_q), .data_oe_q(data_oe_q),
    .xfer_done_q(xfer_done_q), .console_done_q(console_done_q));

`default_nettype wire
